/* File: hw/psb_fifo.sv */
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module psb_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = (count_reg != FULL_CNT);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = store[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
            end
            if (push && !pop) begin
                count_reg <= CNT_W'(count_reg + 1'b1);
            end else if (pop && !push) begin
                count_reg <= CNT_W'(count_reg - 1'b1);
            end
        end
    end
endmodule

/* File: hw/psb_mem.sv */
// Lane-masked storage array with a separate write port and a registered read port.
`timescale 1ns/1ps
module psb_mem #(
    parameter int ADDR_W = 18,
    parameter int LANE_W = 9,
    parameter int LANES = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [LANES-1:0] wr_mask_i,
    input wire logic [LANE_W*LANES-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [LANE_W*LANES-1:0] rd_data_o
);
    logic [LANE_W*LANES-1:0] mem_array [0:(1<<ADDR_W)-1];
    logic [LANE_W*LANES-1:0] rd_data_reg;

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            for (int k = 0; k < LANES; k++) begin
                if (wr_mask_i[k]) begin
                    mem_array[wr_addr_i][k*LANE_W +: LANE_W] <= wr_data_i[k*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Read-first: a write to the same word in the same cycle is not seen here.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= '0;
        end else if (rd_en_i) begin
            rd_data_reg <= mem_array[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_reg;
endmodule

/* File: hw/psb_pkg.sv */
// Shared constants and helper functions for the pipelined burst SRAM port.
package psb_pkg;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int WORD_W = LANE_W * LANES;
    localparam int BEAT_W = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int ENTRY_W = LANES + ADDR_W + WORD_W;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;

    // Low address bits of a burst beat; interleaved order XORs the count, linear order adds it.
    function automatic logic [BEAT_W-1:0] psb_beat_low(input logic [BEAT_W-1:0] start,
                                                       input logic [BEAT_W-1:0] cnt,
                                                       input logic interleaved);
        logic [BEAT_W-1:0] sum;
        sum = start + cnt;
        return interleaved ? (start ^ cnt) : sum;
    endfunction

    // Replaces the lanes of base selected by mask with the lanes of over.
    function automatic logic [WORD_W-1:0] psb_lane_merge(input logic [WORD_W-1:0] base,
                                                         input logic [WORD_W-1:0] over,
                                                         input logic [LANES-1:0] mask);
        logic [WORD_W-1:0] res;
        res = base;
        for (int k = 0; k < LANES; k++) begin
            if (mask[k]) begin
                res[k*LANE_W +: LANE_W] = over[k*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction
endpackage

/* File: hw/psb_port.sv */
// Device side of a pipelined burst SRAM port with two-cycle data latency.
// Notes on behaviour
// - Lane 1 strobe low in a write stores data bits 0-7 and parity 1.
// - Lane 2 strobe low in a write stores data bits 8-15 and parity 2.
// - Any strobe mix is honoured; all high writes nothing.
// - Lane strobes 3 and 4 do nothing in this 18-bit organisation.
// - Burst order input high: beat low bits are start XOR count.
// - Burst order input low: beat low bits are start plus count, modulo four.
// - After the fourth beat the counter wraps and repeats the sequence.
// - Inputs are sampled and read data launched on the rising clock edge.
// - Read loaded in cycle n shows its word in cycle n+2 when enabled.
// - Each advance cycle of a live burst steps the burst; data follows two cycles later.
// - A new load may follow three advances with no gap on the bus.
// - Loads, bursts, deselects and idle cycles mix freely without turnaround gaps.
// - Bus carries sixteen data bits and two lane parity bits both ways.
// - Advance cycles ignore direction; the burst keeps its loaded direction.
// - Suspend sampled high freezes every register and the data pins.
// - Selected only with both active-low selects low and the high select high.
// - Deselect starts nothing, lets pending transfers finish, floats bus two cycles on.
`timescale 1ns/1ps
module psb_port
    import psb_pkg::*;
#(
    parameter int FIFO_DEPTH_P = psb_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clock_suspend_n_i,
    input wire logic [psb_pkg::ADDR_W-1:0] address_i,
    input wire logic read_not_write_i,
    input wire logic advance_or_load_i,
    input wire logic chip_select_a_n_i,
    input wire logic chip_select_b_i,
    input wire logic chip_select_c_n_i,
    input wire logic lane1_write_n_i,
    input wire logic lane2_write_n_i,
    input wire logic lane3_write_n_i,
    input wire logic lane4_write_n_i,
    input wire logic burst_order_select_i,
    input wire logic output_enable_n_i,
    input wire logic [15:0] data_i,
    input wire logic parity_lane1_i,
    input wire logic parity_lane2_i,
    output logic [15:0] data_o,
    output logic parity_lane1_o,
    output logic parity_lane2_o,
    output logic data_oe_n_o,
    output logic write_backlog_full_o
);
    import psb_pkg::*;

    logic run;
    logic selected;
    logic load_sel;
    logic adv_go;
    logic cmd_valid;
    logic cmd_write;
    logic [ADDR_W-1:0] cmd_addr;
    logic [BEAT_W-1:0] cnt_step;
    logic [LANES-1:0] lanes_now;
    logic [WORD_W-1:0] bus_word_in;
    logic [WORD_W-1:0] word_out;

    logic [ADDR_W-1:0] burst_base_reg;
    logic [BEAT_W-1:0] burst_cnt_reg;
    logic burst_wr_reg;
    logic burst_act_reg;

    logic s1_valid_reg;
    logic s1_write_reg;
    logic [ADDR_W-1:0] s1_addr_reg;
    logic [LANES-1:0] s1_lanes_reg;
    logic s2_valid_reg;
    logic s2_write_reg;
    logic [ADDR_W-1:0] s2_addr_reg;
    logic [LANES-1:0] s2_lanes_reg;
    logic rd_phase_reg;

    logic push_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out_data;
    logic [LANES-1:0] head_mask;
    logic [ADDR_W-1:0] head_addr;
    logic [WORD_W-1:0] head_data;
    logic mem_rd_en;
    logic [WORD_W-1:0] mem_rd_data;
    logic [LANES-1:0] fwd_mask_next;
    logic [WORD_W-1:0] fwd_data_next;
    logic [LANES-1:0] fwd_mask_reg;
    logic [WORD_W-1:0] fwd_data_reg;
    logic [ADDR_W-BEAT_W-1:0] load_upper;

    // Every register below advances only on an edge where suspend is low.
    assign run = !clock_suspend_n_i;
    assign selected = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    assign load_sel = run && !advance_or_load_i && selected;
    // An advance without a live burst is an idle cycle and starts nothing.
    assign adv_go = run && advance_or_load_i && burst_act_reg;
    assign cnt_step = BEAT_W'(burst_cnt_reg + BEAT_STEP);
    assign cmd_valid = load_sel || adv_go;
    assign cmd_write = load_sel ? !read_not_write_i : burst_wr_reg;
    assign cmd_addr = load_sel ? address_i :
                      {burst_base_reg[ADDR_W-1:BEAT_W],
                       psb_beat_low(burst_base_reg[BEAT_W-1:0], cnt_step, burst_order_select_i)};
    // Upper address bits of the load cycle, kept so the burst checks can compare against them.
    assign load_upper = address_i[ADDR_W-1:BEAT_W];
    // Only two lanes exist, so the third and fourth strobes are never looked at.
    assign lanes_now = {!lane2_write_n_i, !lane1_write_n_i};
    assign bus_word_in = {parity_lane2_i, data_i[15:8], parity_lane1_i, data_i[7:0]};

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            burst_base_reg <= '0;
            burst_cnt_reg <= BEAT_FIRST;
            burst_wr_reg <= 1'b0;
            burst_act_reg <= 1'b0;
        end else if (run) begin
            if (!advance_or_load_i) begin
                burst_act_reg <= selected;
                if (selected) begin
                    burst_base_reg <= address_i;
                    burst_cnt_reg <= BEAT_FIRST;
                    burst_wr_reg <= !read_not_write_i;
                end
            end else if (burst_act_reg) begin
                burst_cnt_reg <= cnt_step;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_valid_reg <= 1'b0;
            s1_write_reg <= 1'b0;
            s1_addr_reg <= '0;
            s1_lanes_reg <= '0;
            s2_valid_reg <= 1'b0;
            s2_write_reg <= 1'b0;
            s2_addr_reg <= '0;
            s2_lanes_reg <= '0;
        end else if (run) begin
            s1_valid_reg <= cmd_valid;
            s1_write_reg <= cmd_write;
            s1_addr_reg <= cmd_addr;
            s1_lanes_reg <= lanes_now;
            s2_valid_reg <= s1_valid_reg;
            s2_write_reg <= s1_write_reg;
            s2_addr_reg <= s1_addr_reg;
            s2_lanes_reg <= s1_lanes_reg;
        end
    end

    // A read looks up the array one edge after its control cycle; its word leaves the
    // read register in time to be sampled two edges after the control cycle.
    assign mem_rd_en = run && s1_valid_reg && !s1_write_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_phase_reg <= 1'b0;
        end else if (run) begin
            rd_phase_reg <= s1_valid_reg && !s1_write_reg;
        end
    end

    // Write data are taken two edges after the control cycle; an all-high strobe set
    // is dropped here so it costs no backlog slot.
    assign push_valid = run && s2_valid_reg && s2_write_reg && (s2_lanes_reg != '0);
    assign write_backlog_full_o = !fifo_in_ready;

    psb_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH_P)
    ) u_write_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({s2_lanes_reg, s2_addr_reg, bus_word_in}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(run),
        .out_data_o(fifo_out_data)
    );

    assign head_mask = fifo_out_data[ENTRY_W-1 -: LANES];
    assign head_addr = fifo_out_data[WORD_W +: ADDR_W];
    assign head_data = fifo_out_data[WORD_W-1:0];

    psb_mem #(
        .ADDR_W(ADDR_W),
        .LANE_W(LANE_W),
        .LANES(LANES)
    ) u_array (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(fifo_out_valid && run),
        .wr_addr_i(head_addr),
        .wr_mask_i(head_mask),
        .wr_data_i(head_data),
        .rd_en_i(mem_rd_en),
        .rd_addr_i(s1_addr_reg),
        .rd_data_o(mem_rd_data)
    );

    // Writes still queued, or arriving on the bus this edge, are newer than the array.
    // Backlog never exceeds one entry because push and drain stall together.
    always_comb begin
        fwd_mask_next = '0;
        fwd_data_next = head_data;
        if (fifo_out_valid && head_addr == s1_addr_reg) begin
            fwd_mask_next = head_mask;
        end
        if (push_valid && s2_addr_reg == s1_addr_reg) begin
            fwd_data_next = psb_lane_merge(fwd_data_next, bus_word_in, s2_lanes_reg);
            fwd_mask_next = fwd_mask_next | s2_lanes_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fwd_mask_reg <= '0;
            fwd_data_reg <= '0;
        end else if (mem_rd_en) begin
            fwd_mask_reg <= fwd_mask_next;
            fwd_data_reg <= fwd_data_next;
        end
    end

    assign word_out = psb_lane_merge(mem_rd_data, fwd_data_reg, fwd_mask_reg);
    assign data_o = {word_out[16:9], word_out[7:0]};
    assign parity_lane1_o = word_out[8];
    assign parity_lane2_o = word_out[17];
    // Output enable acts at once, like the pin it replaces, so it is not registered.
    assign data_oe_n_o = !(rd_phase_reg && !output_enable_n_i);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence seq_load_read;
        load_sel && read_not_write_i;
    endsequence

    sequence seq_load_write;
        load_sel && !read_not_write_i;
    endsequence

    sequence seq_deselect;
        run && !advance_or_load_i && !selected;
    endsequence

    sequence seq_advance;
        run && advance_or_load_i;
    endsequence

    read_latency_a: assert property (seq_load_read ##1 run |=> rd_phase_reg)
        else $error("Read data phase missing two cycles after load read.");
    bus_float_a: assert property (seq_deselect ##1 run |=> !rd_phase_reg && data_oe_n_o)
        else $error("Data bus still driven two cycles after deselect.");
    select_decode_a: assert property (run && !selected && !advance_or_load_i |=> !s1_valid_reg)
        else $error("Operation started while not selected.");
    oe_gate_a: assert property (!data_oe_n_o |-> rd_phase_reg && !output_enable_n_i)
        else $error("Data pins driven outside an enabled read phase.");
    // Output enable is a direct gate like the pin it stands for, so the state held here is
    // the registered read phase rather than the enable output itself.
    suspend_hold_a: assert property (!run |=> $stable(s1_valid_reg) && $stable(burst_cnt_reg) &&
                                     $stable(data_o) && $stable(rd_phase_reg))
        else $error("State changed on a suspended edge.");
    burst_dir_a: assert property (seq_load_write ##1 seq_advance |=> s1_valid_reg && s1_write_reg)
        else $error("Burst beat lost the loaded write direction.");
    burst_upper_a: assert property (load_sel ##1 adv_go |=>
                                    s1_addr_reg[ADDR_W-1:BEAT_W] == $past(load_upper, 2))
        else $error("Burst changed the upper address bits.");
    linear_order_a: assert property (adv_go && !burst_order_select_i |->
                                     cmd_addr[1:0] == 2'(burst_base_reg[1:0] + burst_cnt_reg + 2'h1))
        else $error("Linear burst address out of order.");
    interleave_order_a: assert property (adv_go && burst_order_select_i |->
                                         cmd_addr[1:0] == (burst_base_reg[1:0] ^ cnt_step))
        else $error("Interleaved burst address out of order.");
    counter_wrap_a: assert property (adv_go && burst_cnt_reg == BEAT_LAST |=> burst_cnt_reg == BEAT_FIRST)
        else $error("Burst counter did not wrap after the fourth beat.");
    lane_mask_a: assert property (seq_load_write ##1 run ##1 run |->
                                  !push_valid || s2_lanes_reg == $past(lanes_now, 2))
        else $error("Write lane mask differs from strobes of the control cycle.");

    // An advance with no live burst is an idle cycle and must start no transfer.
    sequence seq_idle_advance;
        run && advance_or_load_i && !burst_act_reg;
    endsequence

    load_capture_a: assert property (load_sel |=> s1_valid_reg && s1_addr_reg == $past(address_i))
        else $error("Load cycle did not capture its address.");
    advance_step_a: assert property (adv_go |=> s1_valid_reg && s1_write_reg == $past(burst_wr_reg))
        else $error("Burst advance did not start a beat in the burst direction.");
    write_take_a: assert property (seq_load_write ##1 run ##1 run |->
                                   push_valid == ($past(lanes_now, 2) != '0))
        else $error("Write data not taken two run cycles after its load.");
    deselect_idle_a: assert property (seq_deselect ##1 seq_advance |=> !s1_valid_reg)
        else $error("Advance after a deselect started a transfer.");
    idle_advance_a: assert property (seq_idle_advance |=> !s1_valid_reg)
        else $error("Advance without a live burst started a transfer.");
    // The backlog drains one entry on every run edge and gains at most one, so it never fills.
    backlog_room_a: assert property (!write_backlog_full_o)
        else $error("Write backlog filled up.");
endmodule

/* File: verif/psb_ctrl_model.sv */
// Memory controller model that drives write data onto the port's bus two run cycles after each write beat.
`timescale 1ns/1ps
module psb_ctrl_model
    import psb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clock_suspend_n_i,
    input wire logic advance_or_load_i,
    input wire logic read_not_write_i,
    input wire logic chip_select_a_n_i,
    input wire logic chip_select_b_i,
    input wire logic chip_select_c_n_i,
    input wire logic [psb_pkg::WORD_W-1:0] word_i,
    output logic [15:0] data_o,
    output logic parity_lane1_o,
    output logic parity_lane2_o
);
    import psb_pkg::*;

    logic sel;
    logic live_reg;
    logic wr_reg;
    logic [1:0] wv_reg;
    logic [WORD_W-1:0] w1_reg;
    logic [WORD_W-1:0] w2_reg;
    logic [WORD_W-1:0] hold_reg;
    logic [WORD_W-1:0] drive;

    assign sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    // Outside write phases the bus flips every run cycle, so a stale word can never pass for fresh data.
    assign drive = wv_reg[1] ? w2_reg : ~hold_reg;
    assign data_o = {drive[16:9], drive[7:0]};
    assign parity_lane1_o = drive[8];
    assign parity_lane2_o = drive[17];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_reg <= 1'b0;
            wr_reg <= 1'b0;
            wv_reg <= 2'h0;
            w1_reg <= 18'h00000;
            w2_reg <= 18'h00000;
            hold_reg <= 18'h00000;
        end else if (!clock_suspend_n_i) begin
            if (!advance_or_load_i) begin
                live_reg <= sel;
                wr_reg <= !read_not_write_i;
            end
            wv_reg <= {wv_reg[0], advance_or_load_i ? (live_reg && wr_reg) : (sel && !read_not_write_i)};
            w1_reg <= word_i;
            w2_reg <= w1_reg;
            hold_reg <= drive;
        end
    end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the pipelined burst SRAM port with a controller model on its bus.
`timescale 1ns/1ps
module testbench;
    import psb_pkg::*;
    typedef struct packed {
        logic v;
        logic rd;
        logic [1:0] mask;
        logic [ADDR_W-1:0] a;
        logic [WORD_W-1:0] w;
    } psb_phase_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic susp_n = 1'b0;
    logic [ADDR_W-1:0] address = 18'h00000;
    logic rnw = 1'b1;
    logic advance_or_load = 1'b1;
    logic cs_a_n = 1'b1;
    logic cs_b = 1'b0;
    logic cs_c_n = 1'b1;
    logic [3:0] lane_n = 4'hF;
    logic order = 1'b0;
    logic oe_n = 1'b0;
    logic [WORD_W-1:0] wword = 18'h00000;
    logic [15:0] wdata;
    logic wp1;
    logic wp2;
    logic [15:0] dq;
    logic p1;
    logic p2;
    logic oe_n_o;
    logic full;
    logic susp = 1'b0;
    logic oe_off = 1'b0;
    logic order_sel = 1'b0;
    logic live = 1'b0;
    logic dir = 1'b0;
    logic [ADDR_W-1:0] base = 18'h00000;
    logic [1:0] cnt = 2'h0;
    psb_phase_t cur = '0;
    psb_phase_t p1q = '0;
    logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
    int bad_count = 0;
    int check_count = 0;

    psb_port #(.FIFO_DEPTH_P(FIFO_DEPTH)) u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .clock_suspend_n_i(susp_n),
        .address_i(address), .read_not_write_i(rnw), .advance_or_load_i(advance_or_load), .chip_select_a_n_i(cs_a_n),
        .chip_select_b_i(cs_b), .chip_select_c_n_i(cs_c_n), .lane1_write_n_i(lane_n[0]),
        .lane2_write_n_i(lane_n[1]), .lane3_write_n_i(lane_n[2]), .lane4_write_n_i(lane_n[3]),
        .burst_order_select_i(order), .output_enable_n_i(oe_n), .data_i(wdata), .parity_lane1_i(wp1),
        .parity_lane2_i(wp2), .data_o(dq), .parity_lane1_o(p1), .parity_lane2_o(p2), .data_oe_n_o(oe_n_o),
        .write_backlog_full_o(full));
    psb_ctrl_model u_ctrl (.clk_sys_i(clk), .rst_n_i(rst_n), .clock_suspend_n_i(susp_n),
        .advance_or_load_i(advance_or_load), .read_not_write_i(rnw), .chip_select_a_n_i(cs_a_n), .chip_select_b_i(cs_b),
        .chip_select_c_n_i(cs_c_n), .word_i(wword), .data_o(wdata), .parity_lane1_o(wp1), .parity_lane2_o(wp2));

    task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One bus cycle: drive just after an edge, check the settled bus at the falling edge, then track the beat.
    task automatic step(input logic ld, input logic rw, input logic [1:0] dsel, input logic [ADDR_W-1:0] addr,
                        input logic [1:0] m_n, input logic [WORD_W-1:0] word);
        logic [1:0] low;
        advance_or_load <= !ld;
        rnw <= rw;
        address <= addr;
        cs_a_n <= (dsel == 2'h1);
        cs_b <= (dsel != 2'h2);
        cs_c_n <= (dsel == 2'h3);
        lane_n <= {word[1:0], m_n};
        wword <= word;
        susp_n <= susp;
        oe_n <= oe_off;
        order <= order_sel;
        @(negedge clk);
        check("backlog full", full, 1'b0);
        if (cur.v && cur.rd) begin
            check("drive enable", oe_n_o, oe_off);
            check("read word", {p2, dq[15:8], p1, dq[7:0]}, mem[cur.a]);
        end else begin
            check("drive enable", oe_n_o, 1'b1);
            if (cur.v && cur.mask[0]) mem[cur.a][8:0] = cur.w[8:0];
            if (cur.v && cur.mask[1]) mem[cur.a][17:9] = cur.w[17:9];
        end
        if (!susp) begin
            if (ld) begin
                live = (dsel == 2'h0);
                base = addr;
                cnt = 2'h0;
                dir = rw;
            end else begin
                cnt = cnt + 2'h1;
            end
            low = order_sel ? (base[1:0] ^ cnt) : (base[1:0] + cnt);
            cur = p1q;
            p1q = '{live, dir, ~m_n, {base[17:2], low}, word};
        end
        @(posedge clk);
    endtask

    task automatic ld(input logic rw, input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic [WORD_W-1:0] w);
        step(1'b1, rw, 2'h0, a, m, w);
    endtask

    task automatic adv(input logic rw, input logic [WORD_W-1:0] w);
        step(1'b0, rw, 2'h0, 18'h00000, 2'h0, w);
    endtask

    task automatic dsl(input logic [1:0] d);
        step(1'b1, 1'b1, d, 18'h3FFFF, 2'h0, 18'h00000);
    endtask

    function automatic logic [WORD_W-1:0] pat(input int i);
        return WORD_W'(i * 32'h0001357B) ^ 18'h2AC35;
    endfunction

    initial begin
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("idle drive", oe_n_o, 1'b1);
        @(posedge clk);
        order_sel = 1'b1;
        ld(1'b0, 18'h00101, 2'h0, pat(0));
        for (int i = 1; i < 4; i++) adv(i[0], pat(i));
        order_sel = 1'b0;
        ld(1'b0, 18'h2A0F2, 2'h0, pat(4));
        for (int i = 5; i < 10; i++) adv(1'b1, pat(i));
        order_sel = 1'b1;
        ld(1'b1, 18'h00103, 2'h0, 18'h00000);
        for (int i = 0; i < 3; i++) adv(1'b0, 18'h00000);
        order_sel = 1'b0;
        ld(1'b1, 18'h2A0F1, 2'h0, 18'h00000);
        for (int i = 0; i < 5; i++) adv(1'b1, 18'h00000);
        ld(1'b0, 18'h01234, 2'h0, pat(20));
        for (int m = 0; m < 4; m++) ld(1'b0, 18'h01234, m[1:0], pat(21 + m));
        ld(1'b1, 18'h01234, 2'h0, 18'h00000);
        for (int d = 1; d < 4; d++) dsl(d[1:0]);
        adv(1'b1, 18'h00000);
        ld(1'b1, 18'h2A0F0, 2'h0, 18'h00000);
        ld(1'b0, 18'h2A0F0, 2'h2, pat(30));
        ld(1'b1, 18'h2A0F0, 2'h0, 18'h00000);
        dsl(2'h1);
        ld(1'b1, 18'h00100, 2'h0, 18'h00000);
        ld(1'b0, 18'h00104, 2'h0, pat(41));
        susp = 1'b1;
        adv(1'b1, pat(42));
        adv(1'b0, pat(43));
        susp = 1'b0;
        ld(1'b1, 18'h00104, 2'h0, 18'h00000);
        dsl(2'h2);
        oe_off = 1'b1;
        ld(1'b1, 18'h00101, 2'h0, 18'h00000);
        dsl(2'h3);
        dsl(2'h1);
        oe_off = 1'b0;
        dsl(2'h1);
        dsl(2'h2);
        print_verdict();
    end
endmodule
